// File: rtl/srb_parity_check.sv
// parity checker for one received character
`timescale 1ns/1ps
module srb_parity_check #(
  parameter int WIDTH = 9
) (
  // character and frame parity
  input wire logic [WIDTH-1:0] data_i,
  input wire logic [WIDTH-1:0] mask_i,
  input wire logic parity_bit_i,
  // mode: 0 even, 1 odd
  input wire logic odd_i,
  // result
  output logic mismatch_o
);

  if (WIDTH < 1) begin : g_bad_width
    $error("srb_parity_check: WIDTH must be at least 1");
  end

  wire logic expected_bit;

  // bits above the configured size never count
  assign expected_bit = (^(data_i & mask_i)) ^ odd_i;
  assign mismatch_o = expected_bit ^ parity_bit_i;

endmodule

// File: rtl/srb_pkg.sv
// shared constants for the serial receive buffer and status block
package srb_pkg;

  // ***************************************************
  // bus and register map
  // ***************************************************
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] OFS_STATUS_A = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_CONTROL_B = 12'h004;
  localparam logic [ADDR_W-1:0] OFS_CONTROL_C = 12'h008;
  localparam logic [ADDR_W-1:0] OFS_RX_DATA = 12'h00C;

  // ***************************************************
  // field positions
  // ***************************************************
  // serial_status_a
  localparam int STA_RXC_BIT = 7;
  localparam int STA_FE_BIT = 4;
  localparam int STA_DOR_BIT = 3;
  localparam int STA_PE_BIT = 2;
  // serial_control_b
  localparam int CTB_IRQ_EN_BIT = 7;
  localparam int CTB_RX_EN_BIT = 4;
  localparam int CTB_NINTH_BIT = 1;
  // serial_control_c
  localparam int CTC_PM_HI = 5;
  localparam int CTC_PM_LO = 4;
  localparam int CTC_STOP_BIT = 3;
  localparam int CTC_CS_HI = 2;
  localparam int CTC_CS_LO = 0;

  // ***************************************************
  // reset values and encodings
  // ***************************************************
  localparam logic [1:0] PARITY_MODE_RST = 2'h0;
  localparam logic [2:0] CHAR_SIZE_RST = 3'h3;
  localparam logic [2:0] CS_5BIT = 3'h0;
  localparam logic [2:0] CS_6BIT = 3'h1;
  localparam logic [2:0] CS_7BIT = 3'h2;
  localparam logic [2:0] CS_9BIT = 3'h7;
  localparam logic [8:0] MASK_5BIT = 9'h01F;
  localparam logic [8:0] MASK_6BIT = 9'h03F;
  localparam logic [8:0] MASK_7BIT = 9'h07F;
  localparam logic [8:0] MASK_8BIT = 9'h0FF;
  localparam logic [8:0] MASK_9BIT = 9'h1FF;

  // ***************************************************
  // buffer entry layout: character plus its own error flags
  // ***************************************************
  localparam int RX_FIFO_DEPTH = 2;
  localparam int CHAR_W = 9;
  localparam int ENT_PE = 9;
  localparam int ENT_DOR = 10;
  localparam int ENT_FE = 11;
  localparam int ENT_W = 12;

endpackage

// File: rtl/srb_rx_fifo.sv
// small receive fifo with flush, registered fill flag
`timescale 1ns/1ps
module srb_rx_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 2,
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1,
  localparam int CW = $clog2(DEPTH + 1)
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // control
  input wire logic flush_i,
  input wire logic push_i,
  input wire logic [WIDTH-1:0] push_data_i,
  input wire logic pop_i,
  // state
  output logic [WIDTH-1:0] head_o,
  output logic valid_o,
  output logic full_o,
  output logic [CW-1:0] count_o
);

  if (DEPTH < 2) begin : g_bad_depth
    $error("srb_rx_fifo: DEPTH must be at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr_reg;
  logic [PW-1:0] rd_ptr_reg;
  logic [CW-1:0] count_reg;
  logic valid_reg;
  wire logic do_pop;
  wire logic do_push;
  wire logic [CW-1:0] count_next;
  wire logic [PW-1:0] wr_ptr_next;
  wire logic [PW-1:0] rd_ptr_next;

  // a pop on an empty buffer is ignored; a full buffer takes a push only while popping
  assign do_pop = pop_i & (count_reg != '0);
  assign do_push = push_i & ((count_reg != CW'(DEPTH)) | do_pop);
  assign count_next = flush_i ? '0 : CW'(count_reg + CW'(do_push) - CW'(do_pop));
  assign wr_ptr_next = (wr_ptr_reg == PW'(DEPTH - 1)) ? '0 : PW'(wr_ptr_reg + 1'b1);
  assign rd_ptr_next = (rd_ptr_reg == PW'(DEPTH - 1)) ? '0 : PW'(rd_ptr_reg + 1'b1);
  assign head_o = mem[rd_ptr_reg];
  assign valid_o = valid_reg;
  assign full_o = (count_reg == CW'(DEPTH));
  assign count_o = count_reg;

  always_ff @(posedge clk_i) begin
    if (do_push && !flush_i) begin
      mem[wr_ptr_reg] <= push_data_i;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
      valid_reg <= 1'b0;
    end else if (flush_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
      valid_reg <= 1'b0;
    end else begin
      wr_ptr_reg <= do_push ? wr_ptr_next : wr_ptr_reg;
      rd_ptr_reg <= do_pop ? rd_ptr_next : rd_ptr_reg;
      count_reg <= count_next;
      valid_reg <= (count_next != '0);
    end
  end

endmodule

// File: rtl/srb_rx_top.sv
// receive buffer, error flags and status registers of the serial port, apb slave
//
// Overview of operation
// - complete flag set while buffer holds characters
// - receiver disable empties buffer, clears flag
// - interrupt requested while flag, enable, global set
// - data read pops one character
// - error flags stored with their character
// - writes to error flag bits ignored
// - error flags never raise an interrupt
// - frame error is inverted first stop bit
// - only first stop bit is checked
// - overrun when full, holding and start
// - overrun cleared on successful buffer transfer
// - parity flag reads zero when checking off
// - upper mode bit enables, lower selects type
// - parity mismatch stored with the character
// - parity flag only if checked at arrival
// - disable stops reception, discards, flushes, releases
// - enable takes over pin for reception
// - completed frame moves into receive buffer
//
// The placing of the registers and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
module srb_rx_top
  import srb_pkg::*;
#(
  parameter int DEPTH = RX_FIFO_DEPTH
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic [DATA_W-1:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [DATA_W-1:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // from the receive shift register
  input wire logic frame_done_i,
  input wire logic [CHAR_W-1:0] frame_data_i,
  input wire logic frame_stop_i,
  input wire logic frame_parity_i,
  input wire logic start_detect_i,
  // configuration to the receive front end
  output logic receiver_enable_o,
  output logic [2:0] char_size_field_o,
  output logic stop_bit_select_o,
  // interrupt
  input wire logic global_irq_enable_i,
  output logic rx_complete_irq_o,
  output logic rx_complete_flag_o
);

  if (DEPTH < 2) begin : g_bad_depth
    $error("srb_rx_top: DEPTH must be at least 2");
  end

  localparam int CW = $clog2(DEPTH + 1);

  // ***************************************************
  // registers
  // ***************************************************
  logic receiver_enable_reg;
  logic rx_complete_irq_enable_reg;
  logic [1:0] parity_mode_field_reg;
  logic stop_bit_select_reg;
  logic [2:0] char_size_field_reg;
  logic [ENT_W-1:0] hold_entry_reg;
  logic hold_valid_reg;
  logic overrun_pend_reg;
  logic irq_reg;
  logic [DATA_W-1:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;

  // ***************************************************
  // apb decode
  // ***************************************************
  wire logic setup_phase;
  wire logic access_done;
  wire logic sel_status;
  wire logic sel_ctrl_b;
  wire logic sel_ctrl_c;
  wire logic sel_data;
  wire logic addr_hit;
  wire logic wr_ctrl_b;
  wire logic wr_ctrl_c;
  wire logic wr_status;
  wire logic data_pop;

  assign setup_phase = psel_i & ~penable_i;
  // the access ends at the edge where pready is seen high
  assign access_done = psel_i & penable_i & pready_reg;
  assign sel_status = (paddr_i == OFS_STATUS_A);
  assign sel_ctrl_b = (paddr_i == OFS_CONTROL_B);
  assign sel_ctrl_c = (paddr_i == OFS_CONTROL_C);
  assign sel_data = (paddr_i == OFS_RX_DATA);
  assign addr_hit = sel_status | sel_ctrl_b | sel_ctrl_c | sel_data;
  // all fields sit in the low byte lane
  assign wr_ctrl_b = access_done & pwrite_i & sel_ctrl_b & pstrb_i[0];
  assign wr_ctrl_c = access_done & pwrite_i & sel_ctrl_c & pstrb_i[0];
  assign wr_status = access_done & pwrite_i & sel_status;
  assign data_pop = access_done & ~pwrite_i & sel_data;

  // ***************************************************
  // receive path
  // ***************************************************
  wire logic [8:0] size_mask;
  wire logic check_enable;
  wire logic parity_mismatch;
  wire logic [ENT_W-1:0] new_entry;
  wire logic [ENT_W-1:0] push_entry;
  wire logic [ENT_W-1:0] head_entry;
  wire logic fifo_valid;
  wire logic fifo_full;
  wire logic [CW-1:0] fifo_count;
  wire logic accept_frame;
  wire logic push_hold;
  wire logic overrun_set;
  wire logic flush;

  assign size_mask = (char_size_field_reg == CS_5BIT) ? MASK_5BIT :
                     (char_size_field_reg == CS_6BIT) ? MASK_6BIT :
                     (char_size_field_reg == CS_7BIT) ? MASK_7BIT :
                     (char_size_field_reg == CS_9BIT) ? MASK_9BIT : MASK_8BIT;
  assign check_enable = parity_mode_field_reg[1];
  assign flush = ~receiver_enable_reg;
  // frames and start bits are ignored once the receiver is off
  assign accept_frame = frame_done_i & receiver_enable_reg;
  // only the first stop bit is looked at, whatever the stop bit count
  assign new_entry[ENT_FE] = ~frame_stop_i;
  assign new_entry[ENT_PE] = check_enable & parity_mismatch;
  assign new_entry[ENT_DOR] = 1'b0;
  assign new_entry[CHAR_W-1:0] = frame_data_i & size_mask;
  // the overrun mark rides on the entry that leaves the holding stage next
  assign push_entry = {hold_entry_reg[ENT_FE], overrun_pend_reg, hold_entry_reg[ENT_PE:0]};
  assign push_hold = hold_valid_reg & receiver_enable_reg & (~fifo_full | data_pop);
  assign overrun_set = receiver_enable_reg & start_detect_i & fifo_full & hold_valid_reg & ~push_hold;

  srb_parity_check #(
    .WIDTH(CHAR_W)
  ) u_parity (
    .data_i(frame_data_i),
    .mask_i(size_mask),
    .parity_bit_i(frame_parity_i),
    .odd_i(parity_mode_field_reg[0]),
    .mismatch_o(parity_mismatch)
  );

  srb_rx_fifo #(
    .WIDTH(ENT_W),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .flush_i(flush),
    .push_i(push_hold),
    .push_data_i(push_entry),
    .pop_i(data_pop),
    .head_o(head_entry),
    .valid_o(fifo_valid),
    .full_o(fifo_full),
    .count_o(fifo_count)
  );

  // ***************************************************
  // read mux: flags shown belong to the head character
  // ***************************************************
  wire logic [DATA_W-1:0] status_word;
  wire logic [DATA_W-1:0] ctrl_b_word;
  wire logic [DATA_W-1:0] ctrl_c_word;
  wire logic [DATA_W-1:0] data_word;
  wire logic [DATA_W-1:0] read_word;
  wire logic [ENT_W-1:0] head_seen;

  assign head_seen = fifo_valid ? head_entry : '0;
  assign status_word = (DATA_W'(fifo_valid) << STA_RXC_BIT)
                     | (DATA_W'(head_seen[ENT_FE]) << STA_FE_BIT)
                     | (DATA_W'(head_seen[ENT_DOR]) << STA_DOR_BIT)
                     | (DATA_W'(head_seen[ENT_PE] & check_enable) << STA_PE_BIT);
  assign ctrl_b_word = (DATA_W'(rx_complete_irq_enable_reg) << CTB_IRQ_EN_BIT)
                     | (DATA_W'(receiver_enable_reg) << CTB_RX_EN_BIT)
                     | (DATA_W'(head_seen[CHAR_W-1]) << CTB_NINTH_BIT);
  assign ctrl_c_word = (DATA_W'(parity_mode_field_reg) << CTC_PM_LO)
                     | (DATA_W'(stop_bit_select_reg) << CTC_STOP_BIT)
                     | (DATA_W'(char_size_field_reg) << CTC_CS_LO);
  assign data_word = DATA_W'(head_seen[7:0]);
  assign read_word = sel_status ? status_word :
                     sel_ctrl_b ? ctrl_b_word :
                     sel_ctrl_c ? ctrl_c_word :
                     sel_data ? data_word : '0;

  // ***************************************************
  // apb response, one cycle after setup
  // ***************************************************
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= '0;
    end else begin
      pready_reg <= setup_phase;
      pslverr_reg <= setup_phase & ~addr_hit;
      prdata_reg <= (setup_phase & ~pwrite_i) ? read_word : '0;
    end
  end

  // ***************************************************
  // control registers; status bits have no storage to write
  // ***************************************************
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      receiver_enable_reg <= 1'b0;
      rx_complete_irq_enable_reg <= 1'b0;
    end else if (wr_ctrl_b) begin
      receiver_enable_reg <= pwdata_i[CTB_RX_EN_BIT];
      rx_complete_irq_enable_reg <= pwdata_i[CTB_IRQ_EN_BIT];
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      parity_mode_field_reg <= PARITY_MODE_RST;
      stop_bit_select_reg <= 1'b0;
      char_size_field_reg <= CHAR_SIZE_RST;
    end else if (wr_ctrl_c) begin
      parity_mode_field_reg <= pwdata_i[CTC_PM_HI:CTC_PM_LO];
      stop_bit_select_reg <= pwdata_i[CTC_STOP_BIT];
      char_size_field_reg <= pwdata_i[CTC_CS_HI:CTC_CS_LO];
    end
  end

  // ***************************************************
  // holding stage (the completed shift register frame)
  // ***************************************************
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      hold_valid_reg <= 1'b0;
      hold_entry_reg <= '0;
    end else if (!receiver_enable_reg) begin
      hold_valid_reg <= 1'b0;
    end else if (accept_frame) begin
      hold_valid_reg <= 1'b1;
      hold_entry_reg <= new_entry;
    end else if (push_hold) begin
      hold_valid_reg <= 1'b0;
    end
  end

  // no loss is recorded in the transfer cycle: overrun_set excludes push_hold, so set and clear never meet
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      overrun_pend_reg <= 1'b0;
    end else begin
      overrun_pend_reg <= receiver_enable_reg & (overrun_set | (overrun_pend_reg & ~push_hold));
    end
  end

  // level request; error flags take no part in it
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= fifo_valid & rx_complete_irq_enable_reg & global_irq_enable_i;
    end
  end

  assign prdata_o = prdata_reg;
  assign pready_o = pready_reg;
  assign pslverr_o = pslverr_reg;
  assign receiver_enable_o = receiver_enable_reg;
  assign char_size_field_o = char_size_field_reg;
  assign stop_bit_select_o = stop_bit_select_reg;
  assign rx_complete_irq_o = irq_reg;
  assign rx_complete_flag_o = fifo_valid;

  // ***************************************************
  // checks
  // ***************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  chk_disable_flush: assert property (
    !receiver_enable_reg |=> !rx_complete_flag_o && fifo_count == '0 && !hold_valid_reg)
    else $error("buffer not flushed while receiver disabled");

  chk_irq_level: assert property (
    (fifo_valid && rx_complete_irq_enable_reg && global_irq_enable_i)[*2] |-> rx_complete_irq_o)
    else $error("receive interrupt not held while flag set");

  chk_no_err_irq: assert property (
    rx_complete_irq_o |-> $past(fifo_valid && rx_complete_irq_enable_reg && global_irq_enable_i))
    else $error("interrupt raised without a received character");

  chk_pop_on_read: assert property (
    (data_pop && fifo_valid && !push_hold && receiver_enable_reg) |=> fifo_count == $past(fifo_count) - 1'b1)
    else $error("data read did not pop one character");

  chk_status_write_ignored: assert property (
    (wr_status && fifo_valid && receiver_enable_reg) |=> $stable(head_entry[ENT_FE:ENT_PE]))
    else $error("status write changed error flags");

  chk_parity_off_zero: assert property (
    (setup_phase && !pwrite_i && sel_status && !check_enable) |=> !prdata_o[STA_PE_BIT])
    else $error("parity flag read as one with checking off");

  chk_frame_err_stop: assert property (
    accept_frame |=> hold_valid_reg && hold_entry_reg[ENT_FE] == !$past(frame_stop_i))
    else $error("frame error does not follow first stop bit");

  chk_overrun_set: assert property (
    overrun_set |=> overrun_pend_reg)
    else $error("overrun not recorded");

  chk_overrun_attach: assert property (
    (push_hold && overrun_pend_reg) |=> u_fifo.mem[$past(u_fifo.wr_ptr_reg)][ENT_DOR])
    else $error("overrun not attached to transferred character");

  chk_overrun_clear: assert property (
    (push_hold && !overrun_set) |=> !overrun_pend_reg)
    else $error("overrun not cleared on transfer");

endmodule

// File: tb/srb_frame_src.sv
// remote transmitter model handing completed frames to the receive buffer
`timescale 1ns/1ps
module srb_frame_src (
  // clock
  input wire logic clk_i,
  // completed frame and start detection
  output logic frame_done_o,
  output logic [8:0] frame_data_o,
  output logic frame_stop_o,
  output logic frame_parity_o,
  output logic start_detect_o
);
  initial begin
    frame_done_o = 1'h0;
    frame_data_o = 9'h000;
    frame_stop_o = 1'h1;
    frame_parity_o = 1'h0;
    start_detect_o = 1'h0;
  end

  // ***************************************************
  // frame delivery
  // ***************************************************
  // only the first stop bit is handed on, later stop bits never reach the buffer
  task automatic send(input logic [8:0] d, input logic stop, input logic par);
    frame_done_o <= 1'h1;
    frame_data_o <= d;
    frame_stop_o <= stop;
    frame_parity_o <= par;
    @(posedge clk_i);
    frame_done_o <= 1'h0;
    // released lines show the inverse so a stale sample cannot pass
    frame_data_o <= ~d;
    frame_stop_o <= ~stop;
    frame_parity_o <= ~par;
    repeat (3) @(posedge clk_i);
  endtask

  task automatic start_bit;
    start_detect_o <= 1'h1;
    @(posedge clk_i);
    start_detect_o <= 1'h0;
  endtask
endmodule

// File: tb/srb_rx_top_tb.sv
// self-checking bench for the serial receive buffer and status block
`timescale 1ns/1ps
module srb_rx_top_tb;
  import srb_pkg::*;
  localparam logic [DATA_W-1:0] RECEIVER_ENABLE = 32'h1 << CTB_RX_EN_BIT;
  localparam logic [DATA_W-1:0] IRQEN = 32'h1 << CTB_IRQ_EN_BIT;
  logic clk, rst, psel, penable, pwrite, gie, e;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, r;
  wire logic [DATA_W-1:0] prdata;
  wire logic pready, pslverr, fdone, fstop, fpar, fstart, rx_en, sbs, irq, flag;
  wire logic [8:0] fdata;
  wire logic [2:0] csz;
  int n_mismatch = 0;
  int total_checks = 0;

  srb_rx_top dut (.clk_i(clk), .sys_rst_i(rst), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(4'hF), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .frame_done_i(fdone), .frame_data_i(fdata), .frame_stop_i(fstop),
    .frame_parity_i(fpar), .start_detect_i(fstart), .receiver_enable_o(rx_en), .char_size_field_o(csz),
    .stop_bit_select_o(sbs), .global_irq_enable_i(gie), .rx_complete_irq_o(irq), .rx_complete_flag_o(flag));
  srb_frame_src src (.clk_i(clk), .frame_done_o(fdone), .frame_data_o(fdata), .frame_stop_o(fstop),
    .frame_parity_o(fpar), .start_detect_o(fstart));

  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  // ***************************************************
  // shared tasks
  // ***************************************************
  task automatic finish_test;
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                     output logic [DATA_W-1:0] q, output logic qe);
    int n;
    n = 0;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'h1);
    q = prdata;
    qe = pslverr;
    // zero wait states: the answer stands in the first access cycle
    chk(32'(n), 32'h1);
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    apb(1'h1, a, d, r, e);
    chk(32'(e), 32'h0);
  endtask

  task automatic chk_rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] x);
    apb(1'h0, a, '0, r, e);
    chk(r, x);
    chk(32'(e), 32'h0);
  endtask

  // two cycles cover the registered flag and the interrupt lag behind it
  task automatic chk_out(input logic fl, input logic en, input logic iq);
    repeat (2) @(negedge clk);
    chk({29'h0, flag, rx_en, irq}, {29'h0, fl, en, iq});
    @(posedge clk);
  endtask

  function automatic logic [DATA_W-1:0] st(input logic c, input logic f, input logic o, input logic p);
    st = '0;
    st[STA_RXC_BIT] = c;
    st[STA_FE_BIT] = f;
    st[STA_DOR_BIT] = o;
    st[STA_PE_BIT] = p;
  endfunction

  // ***************************************************
  // scenarios
  // ***************************************************
  task automatic t_reset;
    chk_out(1'h0, 1'h0, 1'h0);
    chk_rd(OFS_STATUS_A, '0);
    chk_rd(OFS_CONTROL_B, '0);
    chk_rd(OFS_CONTROL_C, 32'(CHAR_SIZE_RST));
    chk(32'(csz), 32'(CHAR_SIZE_RST));
    apb(1'h0, 12'h010, '0, r, e);
    chk(32'(e), 32'h1);
    chk(r, '0);
  endtask

  task automatic t_basic;
    wr(OFS_CONTROL_B, RECEIVER_ENABLE);
    chk_out(1'h0, 1'h1, 1'h0);
    src.send(9'h041, 1'h1, 1'h0);
    chk_out(1'h1, 1'h1, 1'h0);
    chk_rd(OFS_STATUS_A, st(1'h1, 1'h0, 1'h0, 1'h0));
    chk_rd(OFS_RX_DATA, 32'h0000_0041);
    chk_out(1'h0, 1'h1, 1'h0);
  endtask

  task automatic t_frame;
    wr(OFS_CONTROL_C, 32'h1 << CTC_STOP_BIT | 32'(CHAR_SIZE_RST));
    chk(32'(sbs), 32'h1);
    src.send(9'h055, 1'h0, 1'h0);
    src.send(9'h0AA, 1'h1, 1'h0);
    chk_rd(OFS_STATUS_A, st(1'h1, 1'h1, 1'h0, 1'h0));
    wr(OFS_STATUS_A, '0);
    chk_rd(OFS_STATUS_A, st(1'h1, 1'h1, 1'h0, 1'h0));
    chk_rd(OFS_RX_DATA, 32'h0000_0055);
    chk_rd(OFS_STATUS_A, st(1'h1, 1'h0, 1'h0, 1'h0));
    chk_rd(OFS_RX_DATA, 32'h0000_00AA);
  endtask

  task automatic t_parity;
    logic [1:0] pm;
    logic [8:0] d;
    for (int m = 0; m < 4; m++) begin
      for (int b = 0; b < 2; b++) begin
        pm = 2'(m);
        d = 9'h0B3 ^ 9'(b);
        wr(OFS_CONTROL_C, 32'(pm) << CTC_PM_LO | 32'(CHAR_SIZE_RST));
        src.send(d, 1'h1, (^d) ^ pm[0] ^ b[0]);
        chk_rd(OFS_STATUS_A, st(1'h1, 1'h0, 1'h0, pm[1] & b[0]));
        chk_rd(OFS_RX_DATA, 32'(d));
      end
    end
    // checking switched on only after arrival must not flag the stored character
    wr(OFS_CONTROL_C, 32'(CHAR_SIZE_RST));
    src.send(9'h0B3, 1'h1, 1'h0);
    wr(OFS_CONTROL_C, 32'h2 << CTC_PM_LO | 32'(CHAR_SIZE_RST));
    chk_rd(OFS_STATUS_A, st(1'h1, 1'h0, 1'h0, 1'h0));
    chk_rd(OFS_RX_DATA, 32'h0000_00B3);
    wr(OFS_CONTROL_C, 32'(CHAR_SIZE_RST));
  endtask

  task automatic t_overrun;
    for (int i = 1; i < 4; i++) begin
      src.send(9'(i), 1'h1, 1'h0);
    end
    src.start_bit();
    src.send(9'h004, 1'h1, 1'h0);
    for (int i = 1; i < 4; i++) begin
      chk_rd(OFS_STATUS_A, st(1'h1, 1'h0, i == 3, 1'h0));
      chk_rd(OFS_RX_DATA, i == 3 ? 32'h4 : 32'(i));
    end
    chk_out(1'h0, 1'h1, 1'h0);
    src.send(9'h005, 1'h1, 1'h0);
    chk_rd(OFS_STATUS_A, st(1'h1, 1'h0, 1'h0, 1'h0));
    chk_rd(OFS_RX_DATA, 32'h0000_0005);
  endtask

  task automatic t_irq;
    wr(OFS_CONTROL_B, RECEIVER_ENABLE | IRQEN);
    chk_out(1'h0, 1'h1, 1'h0);
    src.send(9'h011, 1'h0, 1'h0);
    chk_out(1'h1, 1'h1, 1'h1);
    gie <= 1'h0;
    chk_out(1'h1, 1'h1, 1'h0);
    gie <= 1'h1;
    wr(OFS_CONTROL_B, RECEIVER_ENABLE);
    chk_out(1'h1, 1'h1, 1'h0);
    wr(OFS_CONTROL_B, RECEIVER_ENABLE | IRQEN);
    chk_rd(OFS_RX_DATA, 32'h0000_0011);
    chk_out(1'h0, 1'h1, 1'h0);
    wr(OFS_CONTROL_B, RECEIVER_ENABLE);
  endtask

  task automatic t_disable;
    int n;
    src.send(9'h021, 1'h1, 1'h0);
    src.send(9'h022, 1'h1, 1'h0);
    wr(OFS_CONTROL_B, '0);
    chk_out(1'h0, 1'h0, 1'h0);
    src.send(9'h023, 1'h1, 1'h0);
    chk_out(1'h0, 1'h0, 1'h0);
    wr(OFS_CONTROL_B, RECEIVER_ENABLE);
    chk_out(1'h0, 1'h1, 1'h0);
    chk_rd(OFS_RX_DATA, '0);
    src.send(9'h024, 1'h1, 1'h0);
    src.send(9'h025, 1'h1, 1'h0);
    n = 0;
    apb(1'h0, OFS_STATUS_A, '0, r, e);
    while (r[STA_RXC_BIT] === 1'h1 && n < 4) begin
      chk_rd(OFS_RX_DATA, 32'h24 + 32'(n));
      n++;
      apb(1'h0, OFS_STATUS_A, '0, r, e);
    end
    chk(32'(n), 32'h2);
  endtask

  // short characters: upper bits masked, parity over the kept bits only
  task automatic t_size;
    for (int s = 0; s < 3; s++) begin
      wr(OFS_CONTROL_C, 32'h2 << CTC_PM_LO | 32'(s));
      src.send(9'h0FF, 1'h1, 1'(s + 1));
      chk_rd(OFS_STATUS_A, st(1'h1, 1'h0, 1'h0, 1'h0));
      chk_rd(OFS_RX_DATA, (32'h1 << (s + 5)) - 32'h1);
    end
  endtask

  task automatic t_ninth;
    wr(OFS_CONTROL_C, 32'(CS_9BIT));
    chk(32'(csz), 32'(CS_9BIT));
    src.send(9'h1A5, 1'h1, 1'h0);
    chk_rd(OFS_CONTROL_B, RECEIVER_ENABLE | 32'h1 << CTB_NINTH_BIT);
    chk_rd(OFS_RX_DATA, 32'h0000_00A5);
  endtask

  // ***************************************************
  // main sequence and watchdog
  // ***************************************************
  initial begin
    rst = 1'h1;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = '0;
    pwdata = '0;
    gie = 1'h1;
    repeat (20) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    t_reset();
    t_basic();
    t_frame();
    t_parity();
    t_overrun();
    t_irq();
    t_disable();
    t_size();
    t_ninth();
    finish_test();
  end

  // the whole sequence needs well under ten thousand cycles
  initial begin
    #100us;
    n_mismatch++;
    finish_test();
  end
endmodule
